// [rtl/asfe_pkg.sv]
// Purpose: Shared constants for the asynchronous serial frame engine
// Assumes: 8-bit mode word, 4-bit prescale select, 8-bit divisor
// Notes:   All used mode bit positions are defined here; bits 7 and 0 are unused
package asfe_pkg;
   // Mode word field positions
   localparam int MODE_RX_EN_BIT   = 6;   // Receive enable
   localparam int MODE_PAR_HI_BIT  = 5;   // Parity select, upper bit
   localparam int MODE_PAR_LO_BIT  = 4;   // Parity select, lower bit
   localparam int MODE_LEN8_BIT    = 3;   // 1: eight character bits
   localparam int MODE_STOP2_BIT   = 2;   // 1: two stop bits
   localparam int MODE_ERR_MSK_BIT = 1;   // 1: no done event on errored frame
   // Parity select encodings
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_ZERO = 2'h1;
   localparam logic [1:0] PAR_ODD  = 2'h2;
   localparam logic [1:0] PAR_EVEN = 2'h3;
   // Error status encodings
   localparam logic [7:0] ERR_PARITY  = 8'h04;
   localparam logic [7:0] ERR_FRAMING = 8'h02;
   localparam logic [7:0] ERR_OVERRUN = 8'h01;
   // Reset values
   localparam logic [7:0] RX_BUF_RST  = 8'h00;
   localparam logic [7:0] ERR_STS_RST = 8'h00;
   // Baud generator limits
   localparam logic [7:0] DIV_MIN     = 8'h08;  // Smallest legal divisor
   localparam logic [3:0] PRE_MAX     = 4'h9;   // Largest legal prescale select
   // Transmitter states
   typedef enum logic [2:0] {
      TX_IDLE  = 3'b000,
      TX_START = 3'b001,
      TX_DATA  = 3'b010,
      TX_PAR   = 3'b011,
      TX_STOP1 = 3'b100,
      TX_STOP2 = 3'b101
   } asfe_tx_state_t;
   // Receiver states
   typedef enum logic [2:0] {
      RX_IDLE  = 3'b000,
      RX_HALF  = 3'b001,
      RX_DATA  = 3'b010,
      RX_PAR   = 3'b011,
      RX_STOP  = 3'b100
   } asfe_rx_state_t;
endpackage

// [rtl/asfe_brg_if.sv]
// Purpose: Carries baud settings to the generator and its tick back
// Assumes: Single clock domain
// Notes:   Settings are levels, tick is a one-cycle pulse
`timescale 1ns/10ps
interface asfe_brg_if;
   logic [3:0] prescale_select;  // Power-of-two prescale exponent
   logic [7:0] divisor_value;    // Counter divisor, 8 to 255
   logic       sck_tick;         // One pulse per counter source clock
   logic       brg_ok;           // Settings are in the legal range
   modport gen (input prescale_select, input divisor_value, output sck_tick, output brg_ok);
   modport use_side (output prescale_select, output divisor_value, input sck_tick,
                     input brg_ok);
endinterface

// [rtl/asfe_brg.sv]
// Purpose: Prescaler producing the 8-bit counter source clock tick
// Assumes: sys_clk is the main clock
// Notes:   Tick rate is sys_clk / 2^(m+1); illegal settings stop the tick
`timescale 1ns/10ps
module asfe_brg #(
   parameter int PRE_W = 10  // Prescaler width, must hold 2^(PRE_MAX+1)-1
) (
   input  wire logic  sys_clk,
   input  wire logic  rst,
   asfe_brg_if.gen    brg
);
   import asfe_pkg::*;

   if (PRE_W < 10) begin : g_chk
      $error("asfe_brg: PRE_W too small for prescale range");
   end

   logic [PRE_W-1:0] pre_cnt_reg;   // Free-running prescaler count
   logic [PRE_W-1:0] pre_cnt_next;
   logic [PRE_W-1:0] pre_term;      // Terminal count for selected exponent
   logic             tick_reg;      // Registered source clock tick
   logic             tick_next;

   assign brg.brg_ok = (brg.prescale_select <= PRE_MAX) && (brg.divisor_value >= DIV_MIN);
   assign brg.sck_tick = tick_reg;

   // Terminal count and next prescaler value
   always_comb begin
      pre_term  = PRE_W'((32'h1 << (32'(brg.prescale_select) + 32'h1)) - 32'h1);
      tick_next = 1'b0;
      pre_cnt_next = pre_cnt_reg + PRE_W'(1);
      if (!brg.brg_ok) begin
         // Held still so an illegal setting never produces bit timing
         pre_cnt_next = '0;
      end else if (pre_cnt_reg >= pre_term) begin
         pre_cnt_next = '0;
         tick_next    = 1'b1;
      end
   end

   // Register prescaler state
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pre_cnt_reg <= '0;
         tick_reg    <= 1'b0;
      end else begin
         pre_cnt_reg <= pre_cnt_next;
         tick_reg    <= tick_next;
      end
   end
endmodule

// [rtl/asfe_top.sv]
// Purpose: One-channel asynchronous serial transmitter and receiver
// Assumes: Settings and strobes come from logic on sys_clk
// Notes:   Mode is 8 bits; serial_rx_pin is asynchronous and synchronised here
`timescale 1ns/10ps
module asfe_top (
   input  wire logic        sys_clk,          // Main clock, 40 MHz
   input  wire logic        rst,              // Asynchronous reset, active high
   input  wire logic [7:0]  uart_mode_reg,    // Mode word
   input  wire logic [3:0]  prescale_select,  // Baud prescale exponent m
   input  wire logic [7:0]  divisor_value,    // Baud divisor k
   input  wire logic        tx_wr,            // Write strobe into transmit shifter
   input  wire logic [7:0]  tx_data,          // Data for tx_wr
   input  wire logic        tx_flag_clr,      // Clears tx_irq_flag
   input  wire logic        rx_rd,            // Read strobe of the receive buffer
   input  wire logic        serial_rx_pin,    // Line input
   output logic             serial_tx_pin,    // Line output
   output logic [7:0]       rx_buffer_reg,    // Received character
   output logic [7:0]       rx_error_status,  // Error status of last frame
   output logic             tx_busy,          // Transmission in progress
   output logic             tx_done_irq,      // Pulse, transmission complete
   output logic             tx_irq_flag,      // Sticky transmit-done flag
   output logic             rx_done_irq,      // Pulse, reception complete
   output logic             rx_error_irq      // Pulse, reception had an error
);
   import asfe_pkg::*;

   asfe_brg_if brg ();  // Baud settings and tick

   assign brg.prescale_select = prescale_select;
   assign brg.divisor_value   = divisor_value;

   asfe_brg #(.PRE_W(10)) u_brg (
      .sys_clk (sys_clk),
      .rst     (rst),
      .brg     (brg)
   );

   // Decoded mode fields
   logic       rx_en;     // Receiver enabled
   logic       len8;      // Eight character bits
   logic       stop2;     // Two stop bits on transmit
   logic       err_msk;   // Suppress done on error
   logic [1:0] par_sel;   // Parity mode
   assign rx_en   = uart_mode_reg[MODE_RX_EN_BIT];
   assign len8    = uart_mode_reg[MODE_LEN8_BIT];
   assign stop2   = uart_mode_reg[MODE_STOP2_BIT];
   assign err_msk = uart_mode_reg[MODE_ERR_MSK_BIT];
   assign par_sel = uart_mode_reg[MODE_PAR_HI_BIT:MODE_PAR_LO_BIT];

   // Last bit index for the chosen character length
   function automatic logic [2:0] last_bit(input logic is8);
      return is8 ? 3'h7 : 3'h6;
   endfunction

   // Character with bit 7 forced low in seven-bit mode
   function automatic logic [7:0] char_mask(input logic [7:0] d, input logic is8);
      return is8 ? d : {1'b0, d[6:0]};
   endfunction

   // Seven-bit frames shift in one bit short; realign and zero bit 7
   function automatic logic [7:0] rx_data_fix(input logic [7:0] s, input logic is8);
      return is8 ? s : {1'b0, s[7:1]};
   endfunction

   // ---------------- Transmitter ----------------
   asfe_tx_state_t tx_state_reg, tx_state_next;
   logic [7:0] tx_shift_reg, tx_shift_next;   // Transmit shifter
   logic [7:0] tx_cnt_reg,   tx_cnt_next;     // Ticks within a bit
   logic [2:0] tx_bit_reg,   tx_bit_next;     // Character bit index
   logic       tx_par_reg,   tx_par_next;     // Parity bit to send
   logic       tx_pin_reg,   tx_pin_next;     // Line drive
   logic       tx_done_next;
   logic       tx_flag_next;
   logic       tx_bit_end;                    // Current bit time elapses

   assign tx_bit_end = brg.sck_tick && (tx_cnt_reg == divisor_value - 8'h01);

   // Next transmit state; a stopped tick simply freezes the frame and line
   always_comb begin
      tx_state_next = tx_state_reg;
      tx_shift_next = tx_shift_reg;
      tx_cnt_next   = tx_cnt_reg;
      tx_bit_next   = tx_bit_reg;
      tx_par_next   = tx_par_reg;
      tx_pin_next   = tx_pin_reg;
      tx_done_next  = 1'b0;
      if (tx_state_reg != TX_IDLE && brg.sck_tick) begin
         tx_cnt_next = tx_bit_end ? 8'h00 : tx_cnt_reg + 8'h01;
      end
      case (tx_state_reg)
         TX_IDLE: begin
            tx_pin_next = 1'b1;
            if (tx_wr) begin
               tx_shift_next = char_mask(tx_data, len8);
               tx_cnt_next   = 8'h00;
               tx_bit_next   = 3'h0;
               case (par_sel)
                  PAR_EVEN: tx_par_next = ^char_mask(tx_data, len8);
                  PAR_ODD:  tx_par_next = ~^char_mask(tx_data, len8);
                  default:  tx_par_next = 1'b0;
               endcase
               tx_pin_next   = 1'b0;
               tx_state_next = TX_START;
            end
         end
         TX_START: begin
            if (tx_bit_end) begin
               tx_pin_next   = tx_shift_reg[0];
               tx_shift_next = {1'b0, tx_shift_reg[7:1]};
               tx_state_next = TX_DATA;
            end
         end
         TX_DATA: begin
            if (tx_bit_end) begin
               if (tx_bit_reg == last_bit(len8)) begin
                  // no parity goes straight to stop
                  if (par_sel == PAR_NONE) begin
                     tx_pin_next   = 1'b1;
                     tx_state_next = TX_STOP1;
                  end else begin
                     tx_pin_next   = tx_par_reg;
                     tx_state_next = TX_PAR;
                  end
               end else begin
                  tx_pin_next   = tx_shift_reg[0];
                  tx_shift_next = {1'b0, tx_shift_reg[7:1]};
                  tx_bit_next   = tx_bit_reg + 3'h1;
               end
            end
         end
         TX_PAR: begin
            if (tx_bit_end) begin
               tx_pin_next   = 1'b1;
               tx_state_next = TX_STOP1;
            end
         end
         TX_STOP1: begin
            if (tx_bit_end) begin
               tx_state_next = stop2 ? TX_STOP2 : TX_IDLE;
               tx_done_next  = !stop2;
            end
         end
         TX_STOP2: begin
            if (tx_bit_end) begin
               tx_state_next = TX_IDLE;
               tx_done_next  = 1'b1;
            end
         end
         default: begin
            tx_state_next = TX_IDLE;
            tx_pin_next   = 1'b1;
         end
      endcase
      tx_flag_next = tx_done_next | (tx_irq_flag & ~tx_flag_clr);
   end

   // Register transmit state
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tx_state_reg <= TX_IDLE;
         tx_shift_reg <= 8'h00;
         tx_cnt_reg   <= 8'h00;
         tx_bit_reg   <= 3'h0;
         tx_par_reg   <= 1'b0;
         tx_pin_reg   <= 1'b1;
         tx_done_irq  <= 1'b0;
         tx_irq_flag  <= 1'b0;
      end else begin
         tx_state_reg <= tx_state_next;
         tx_shift_reg <= tx_shift_next;
         tx_cnt_reg   <= tx_cnt_next;
         tx_bit_reg   <= tx_bit_next;
         tx_par_reg   <= tx_par_next;
         tx_pin_reg   <= tx_pin_next;
         tx_done_irq  <= tx_done_next;
         tx_irq_flag  <= tx_flag_next;
      end
   end

   assign serial_tx_pin = tx_pin_reg;
   assign tx_busy       = (tx_state_reg != TX_IDLE);

   // ---------------- Receiver ----------------
   logic [2:0] rx_sync_reg;          // Three-stage line synchroniser
   logic       rx_line_reg;          // Filtered line level
   logic       rx_line_next;

   // Line changes only when stages two and three agree
   always_comb begin
      rx_line_next = (rx_sync_reg[1] == rx_sync_reg[2]) ? rx_sync_reg[2] : rx_line_reg;
   end

   // Register synchroniser; resets to idle-high so no false start
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rx_sync_reg <= 3'b111;
         rx_line_reg <= 1'b1;
      end else begin
         rx_sync_reg <= {rx_sync_reg[1:0], serial_rx_pin};
         rx_line_reg <= rx_line_next;
      end
   end

   asfe_rx_state_t rx_state_reg, rx_state_next;
   logic [7:0] rx_shift_reg, rx_shift_next;   // Receive shifter
   logic [7:0] rx_cnt_reg,   rx_cnt_next;     // Ticks within a bit
   logic [2:0] rx_bit_reg,   rx_bit_next;     // Character bit index
   logic       rx_par_reg,   rx_par_next;     // Received parity bit
   logic       rx_prev_reg;                   // Line one cycle ago
   logic [7:0] rx_buf_next;
   logic [7:0] rx_sts_next;
   logic       rx_full_reg,  rx_full_next;    // Buffer holds unread data
   logic       rx_pend_reg,  rx_pend_next;    // Done event waits one cycle
   logic       rx_err_next;
   logic       rx_bit_end;                    // Full bit time elapses
   logic       rx_half_end;                   // Half bit time elapses
   logic       rx_frame_end;                  // Stop bit sampled
   logic [7:0] rx_err_code;                   // Errors of this frame

   assign rx_bit_end  = brg.sck_tick && (rx_cnt_reg == divisor_value - 8'h01);
   assign rx_half_end = brg.sck_tick && (rx_cnt_reg == {1'b0, divisor_value[7:1]} - 8'h01);

   // Next receive state
   always_comb begin
      rx_state_next = rx_state_reg;
      rx_shift_next = rx_shift_reg;
      rx_cnt_next   = rx_cnt_reg;
      rx_bit_next   = rx_bit_reg;
      rx_par_next   = rx_par_reg;
      rx_frame_end  = 1'b0;
      rx_err_code   = 8'h00;
      if (rx_state_reg != RX_IDLE && brg.sck_tick) begin
         rx_cnt_next = rx_cnt_reg + 8'h01;
      end
      case (rx_state_reg)
         RX_IDLE: begin
            if (rx_en && rx_prev_reg && !rx_line_reg) begin
               rx_cnt_next   = 8'h00;
               rx_state_next = RX_HALF;
            end
         end
         RX_HALF: begin
            // still low at half bit accepts start
            if (rx_half_end) begin
               rx_cnt_next   = 8'h00;
               rx_bit_next   = 3'h0;
               rx_shift_next = 8'h00;
               rx_state_next = rx_line_reg ? RX_IDLE : RX_DATA;
            end
         end
         RX_DATA: begin
            if (rx_bit_end) begin
               rx_cnt_next   = 8'h00;
               rx_shift_next = {rx_line_reg, rx_shift_reg[7:1]};
               rx_bit_next   = rx_bit_reg + 3'h1;
               if (rx_bit_reg == last_bit(len8)) begin
                  rx_state_next = (par_sel == PAR_NONE) ? RX_STOP : RX_PAR;
               end
            end
         end
         RX_PAR: begin
            if (rx_bit_end) begin
               rx_cnt_next   = 8'h00;
               rx_par_next   = rx_line_reg;
               rx_state_next = RX_STOP;
            end
         end
         RX_STOP: begin
            // one stop sample ends the frame
            if (rx_bit_end) begin
               rx_state_next = RX_IDLE;
               rx_frame_end  = 1'b1;
               if (!rx_line_reg) begin
                  rx_err_code = rx_err_code | ERR_FRAMING;
               end
               if ((par_sel == PAR_EVEN && (^{rx_data_fix(rx_shift_reg, len8), rx_par_reg}))
                   || (par_sel == PAR_ODD && !(^{rx_data_fix(rx_shift_reg, len8),
                                                 rx_par_reg}))) begin
                  rx_err_code = rx_err_code | ERR_PARITY;
               end
               if (rx_full_reg && !rx_rd) begin
                  rx_err_code = rx_err_code | ERR_OVERRUN;
               end
            end
         end
         default: begin
            rx_state_next = RX_IDLE;
         end
      endcase
      // enable low aborts at once, no events
      if (!rx_en) begin
         rx_state_next = RX_IDLE;
         rx_frame_end  = 1'b0;
      end
   end

   // Buffer, status and event sequencing
   always_comb begin
      rx_buf_next  = rx_buffer_reg;
      rx_sts_next  = rx_error_status;
      rx_full_next = rx_full_reg;
      rx_err_next  = 1'b0;
      rx_pend_next = 1'b0;
      if (rx_rd) begin
         rx_sts_next  = 8'h00;
         rx_full_next = 1'b0;
      end
      if (rx_frame_end) begin
         rx_buf_next  = rx_data_fix(rx_shift_next, len8);
         rx_sts_next  = rx_err_code;
         rx_full_next = 1'b1;
         rx_err_next  = (rx_err_code != 8'h00);
         rx_pend_next = (rx_err_code == 8'h00) || !err_msk;
      end
   end

   // Register receive state; stopped tick keeps partial data
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rx_state_reg    <= RX_IDLE;
         rx_shift_reg    <= 8'h00;
         rx_cnt_reg      <= 8'h00;
         rx_bit_reg      <= 3'h0;
         rx_par_reg      <= 1'b0;
         rx_prev_reg     <= 1'b1;
         rx_buffer_reg   <= RX_BUF_RST;
         rx_error_status <= ERR_STS_RST;
         rx_full_reg     <= 1'b0;
         rx_pend_reg     <= 1'b0;
         rx_error_irq    <= 1'b0;
         rx_done_irq     <= 1'b0;
      end else begin
         rx_state_reg    <= rx_state_next;
         rx_shift_reg    <= rx_shift_next;
         rx_cnt_reg      <= rx_cnt_next;
         rx_bit_reg      <= rx_bit_next;
         rx_par_reg      <= rx_par_next;
         rx_prev_reg     <= rx_line_reg;
         rx_buffer_reg   <= rx_buf_next;
         rx_error_status <= rx_sts_next;
         rx_full_reg     <= rx_full_next;
         rx_pend_reg     <= rx_pend_next;
         rx_error_irq    <= rx_err_next;
         rx_done_irq     <= rx_pend_reg;
      end
   end

   // ---------------- Checks ----------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence s_err_evt;
      rx_error_irq && !err_msk;
   endsequence
   sequence s_done_evt;
      rx_done_irq;
   endsequence

   a_tx_idle_high:   assert property (tx_state_reg == TX_IDLE |-> serial_tx_pin)
      else $error("line not high while idle");
   a_tx_start_low:   assert property (tx_state_reg == TX_START |-> !serial_tx_pin)
      else $error("start bit not low");
   a_tx_zero_par:    assert property (tx_state_reg == TX_PAR && par_sel == PAR_ZERO
                                      |-> !serial_tx_pin)
      else $error("zero parity bit not low");
   a_tx_done_flag:   assert property (tx_done_irq |-> tx_irq_flag && !tx_busy)
      else $error("done without flag or idle");
   a_err_then_done:  assert property (s_err_evt |=> s_done_evt)
      else $error("done did not follow error");
   a_mask_suppress:  assert property (rx_error_irq && err_msk |=> !rx_done_irq)
      else $error("done raised on masked error");
   a_rd_clears_sts:  assert property (rx_rd && !rx_frame_end |=> rx_error_status == 8'h00)
      else $error("buffer read left status");
   a_abort_idle:     assert property (!rx_en |=> rx_state_reg == RX_IDLE && !rx_error_irq)
      else $error("reception not aborted");
   a_overrun_code:   assert property (rx_frame_end && rx_full_reg && !rx_rd
                                      |=> rx_error_status[0] && rx_error_irq)
      else $error("overrun not reported");
   a_seven_bit_zero: assert property (rx_frame_end && !len8 |=> !rx_buffer_reg[7])
      else $error("bit 7 set in seven-bit mode");
endmodule

// [tb/asfe_line_model.sv]
// Purpose: Remote serial transceiver standing on the line
// Assumes: m=0, k=8, so 16 sys_clk cycles per bit
// Notes:   Line rests high between frames, as a real idle line does
`timescale 1ns/10ps
module asfe_line_model (
   input  wire logic sys_clk,
   input  wire logic serial_tx_pin,
   output logic      line_out
);
   localparam int BT = 16;  // Cycles per bit at the chosen baud setting
   initial line_out = 1'b1;
   task automatic send(input logic [11:0] bits, input int n);
      for (int i = 0; i < n; i++) begin
         line_out = bits[i];
         repeat (BT) @(posedge sys_clk);
         #2;
      end
      line_out = 1'b1;
   endtask
   task automatic low(input int n);
      line_out = 1'b0;
      repeat (n) @(posedge sys_clk);
      #2 line_out = 1'b1;
   endtask
   task automatic grab(output logic [11:0] bits, input int n);
      bits = 12'hFFF;
      @(negedge serial_tx_pin);
      repeat (BT/2) @(posedge sys_clk);
      for (int i = 0; i < n; i++) begin
         bits[i] = serial_tx_pin;
         repeat (BT) @(posedge sys_clk);
      end
   endtask
endmodule

// [tb/asfe_top_bench.sv]
// Purpose: Self-checking bench for the serial frame engine
// Assumes: Baud at m=0, k=8, except an illegal m during the hold test; inputs move 2 ns after the edge
// Notes:   Event pulses are counted, then compared per frame
`timescale 1ns/10ps
module asfe_top_bench;
   import asfe_pkg::*;
   logic        sys_clk, rst, tx_wr, tx_flag_clr, rx_rd, line, stx;
   logic [7:0]  mode, tx_data, rbuf, rsts;
   logic        busy, txd, txf, rxd, rxe, e_q;  // Outputs, error delayed
   logic [11:0] got;                            // Captured transmit frame
   logic [3:0]  pre;                            // Prescale, illegal value freezes
   int          n_fail, compares, n_txd, n_rxd, n_rxe, n_ord;
   asfe_top dut (.sys_clk(sys_clk), .rst(rst), .uart_mode_reg(mode), .prescale_select(pre),
      .divisor_value(8'h08), .tx_wr(tx_wr), .tx_data(tx_data), .tx_flag_clr(tx_flag_clr),
      .rx_rd(rx_rd), .serial_rx_pin(line), .serial_tx_pin(stx), .rx_buffer_reg(rbuf),
      .rx_error_status(rsts), .tx_busy(busy), .tx_done_irq(txd), .tx_irq_flag(txf),
      .rx_done_irq(rxd), .rx_error_irq(rxe));
   asfe_line_model m (.sys_clk(sys_clk), .serial_tx_pin(stx), .line_out(line));
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // Pulse counters; done right after error counts as well ordered
   always @(posedge sys_clk) begin
      e_q <= rxe;
      if (txd === 1'b1) n_txd++;
      if (rxd === 1'b1) n_rxd++;
      if (rxe === 1'b1) n_rxe++;
      if (rxd === 1'b1 && e_q === 1'b1) n_ord++;
   end
   task automatic chk(input string nm, input logic [11:0] s, input logic [11:0] e);
      compares++;
      if (s !== e) begin
         n_fail++;
         $display("MISMATCH %s exp %h seen %h", nm, e, s);
      end
   endtask
   task automatic end_of_test;
      if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   function automatic logic [7:0] md(input logic [1:0] p, input logic l8, s2, mk);
      return {1'b0, 1'b1, p, l8, s2, mk, 1'b0};
   endfunction
   function automatic int nb(input logic [7:0] c);
      return 2 + (c[3] ? 8 : 7) + (c[5:4] != PAR_NONE) + c[2];
   endfunction
   // Expected frame bits, parity or stop optionally spoiled
   function automatic logic [11:0] frm(input logic [7:0] d, c, input logic pe, fe);
      logic [11:0] b;
      int          w;
      logic        x;
      b = 12'hFFF;
      b[0] = 1'b0;
      w = c[3] ? 8 : 7;
      x = ^(d & (c[3] ? 8'hFF : 8'h7F));
      for (int i = 0; i < w; i++) b[i+1] = d[i];
      if (c[5:4] != PAR_NONE) begin
         b[w+1] = pe ^ ((c[5:4] == PAR_EVEN) ? x : (c[5:4] == PAR_ODD) ? ~x : 1'b0);
         w++;
      end
      b[w+1] = ~fe;
      return b;
   endfunction
   task automatic pulse_rd;
      rx_rd = 1'b1;
      @(posedge sys_clk);
      #2 rx_rd = 1'b0;
   endtask
   task automatic txc(input logic [7:0] c, d);
      int t;
      t = n_txd;
      mode = c;  // mode set only while idle
      fork
         m.grab(got, nb(c));
         begin
            tx_data = d;
            tx_wr = 1'b1;
            @(posedge sys_clk);
            #2 tx_wr = 1'b0;
            chk("busy", busy, 1'b1);
         end
      join
      repeat (2) @(posedge sys_clk);
      #2 chk("txframe", got, frm(d, c, 1'b0, 1'b0));
      chk("txdone", n_txd - t, 1);
      chk("txflag", txf, 1'b1);
      chk("txidle", busy, 1'b0);
      tx_flag_clr = 1'b1;
      @(posedge sys_clk);
      #2 tx_flag_clr = 1'b0;
      chk("flagclr", txf, 1'b0);
   endtask
   task automatic rxc(input logic [7:0] c, d, input logic pe, fe, input logic [7:0] eb, es,
                      input int ed, input logic rd);
      int e0, d0, o0;
      mode = c;
      e0 = n_rxe;
      d0 = n_rxd;
      o0 = n_ord;
      m.send(frm(d, c, pe, fe), nb(c));
      repeat (4) @(posedge sys_clk);
      #2 chk("rxsts", rsts, es);
      chk("rxbuf", rbuf, eb);
      chk("rxerr", n_rxe - e0, es != 0);
      chk("rxdone", n_rxd - d0, ed);
      chk("order", n_ord - o0, es != 0 && ed != 0);
      if (rd) begin
         pulse_rd;  // read only when rd is set
         chk("rdclr", rsts, 8'h00);
      end
   endtask
   initial begin
      int e0;
      rst = 1'b1;
      tx_wr = 1'b0;
      tx_flag_clr = 1'b0;
      rx_rd = 1'b0;
      tx_data = 8'h00;
      mode = 8'h00;
      pre = 4'h0;
      repeat (12) @(posedge sys_clk);
      #2 rst = 1'b0;
      repeat (4) @(posedge sys_clk);
      #2 chk("idle", stx, 1'b1);
      txc(md(PAR_EVEN, 1, 1, 0), 8'hA7);
      txc(md(PAR_ODD, 0, 0, 0), 8'hFF);
      txc(md(PAR_ZERO, 1, 0, 0), 8'h81);
      txc(md(PAR_NONE, 1, 0, 0), 8'h3C);
      rxc(md(PAR_EVEN, 1, 0, 0), 8'hA5, 0, 0, 8'hA5, 8'h00, 1, 1);
      rxc(md(PAR_EVEN, 1, 1, 0), 8'h3C, 1, 0, 8'h3C, ERR_PARITY, 1, 1);
      rxc(md(PAR_ODD, 1, 0, 0), 8'h5A, 1, 0, 8'h5A, ERR_PARITY, 1, 1);
      rxc(md(PAR_ODD, 1, 0, 0), 8'h5B, 0, 0, 8'h5B, 8'h00, 1, 1);
      rxc(md(PAR_ZERO, 1, 0, 0), 8'h11, 1, 0, 8'h11, 8'h00, 1, 1);
      rxc(md(PAR_NONE, 1, 0, 0), 8'hC3, 0, 1, 8'hC3, ERR_FRAMING, 1, 1);
      rxc(md(PAR_NONE, 0, 0, 0), 8'hFF, 0, 0, 8'h7F, 8'h00, 1, 1);
      rxc(md(PAR_EVEN, 1, 0, 1), 8'h01, 1, 0, 8'h01, ERR_PARITY, 0, 1);
      rxc(md(PAR_NONE, 1, 0, 0), 8'h22, 0, 0, 8'h22, 8'h00, 1, 0);
      rxc(md(PAR_NONE, 1, 0, 0), 8'h33, 0, 0, 8'h33, ERR_OVERRUN, 1, 1);
      e0 = n_rxe + n_rxd;
      m.low(5);
      repeat (30) @(posedge sys_clk);
      #2;
      fork
         m.send(frm(8'h44, mode, 0, 0), nb(mode));
         begin
            repeat (60) @(posedge sys_clk);
            #2 mode[MODE_RX_EN_BIT] = 1'b0;
         end
      join
      repeat (4) @(posedge sys_clk);
      #2 chk("abort", n_rxe + n_rxd - e0, 0);
      chk("abuf", rbuf, 8'h33);
      chk("asts", rsts, 8'h00);
      e0 = n_txd;
      tx_wr = 1'b1;
      @(posedge sys_clk);
      #2 tx_wr = 1'b0;
      repeat (40) @(posedge sys_clk);
      #2 pre = 4'hF;
      repeat (2) @(posedge sys_clk);
      #2 got[0] = stx;
      repeat (50) @(posedge sys_clk);
      #2 chk("hold", stx, got[0]);
      chk("hbusy", busy, 1'b1);
      pre = 4'h0;
      repeat (200) @(posedge sys_clk);
      #2 chk("resume", n_txd - e0, 1);
      end_of_test;
   end
   initial begin
      #500000;
      n_fail++;
      end_of_test;
   end
endmodule
